// >>> core/timer_channel_status_flags.sv
// Status flags of the channels of a multi-channel 16-bit timer, on a Wishbone slave.
// Assumes the counter datapath delivers wrap events and direction on the same clock.
// Wrap events must be one-cycle pulses; a held wrap keeps setting its flag.
`timescale 1ns/100ps
`include "channel_status_params.svh"

module timer_channel_status_flags #(
    parameter int                          NUM_CHANNELS = `CS_MAX_CHANNELS,
    parameter logic [`CS_MAX_CHANNELS-1:0] FULL_MASK    = `CS_FULL_MASK_RESET
) (
    input  wire logic                                  clock,
    input  wire logic                                  resetn,
    input  wire logic                                  wb_cyc_i,
    input  wire logic                                  wb_stb_i,
    input  wire logic                                  wb_we_i,
    input  wire logic [`CS_ADR_W-1:0]                  wb_adr_i,
    input  wire logic [3:0]                            wb_sel_i,
    input  wire logic [31:0]                           wb_dat_i,
    output wire logic [31:0]                           wb_dat_o,
    output wire logic                                  wb_ack_o,
    input  wire channel_status_pkg::counter_events_s   counter_events,
    output wire channel_status_pkg::status_flags_s     status_flags
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (NUM_CHANNELS < 1 || NUM_CHANNELS > `CS_MAX_CHANNELS) begin : g_bad_count
        $error("NUM_CHANNELS out of range");
    end

    if ((1 << `CS_CH_IDX_W) < `CS_MAX_CHANNELS) begin : g_bad_index
        $error("Channel index too narrow");
    end

    if (`CS_STATUS_STRIDE < 8'h04) begin : g_bad_stride
        $error("Status stride below one word");
    end

    if (NUM_CHANNELS * `CS_STATUS_STRIDE + `CS_STATUS_BASE > (1 << `CS_ADR_W)) begin : g_bad_span
        $error("Status registers do not fit the address space");
    end

    if (`CS_DIR_BIT > 7 || `CS_RSV6_BIT > 7 || `CS_UNF_BIT > 7 || `CS_OVF_BIT > 7) begin : g_bad_field
        $error("Status field outside the byte");
    end

    if (`CS_UNF_BIT == `CS_OVF_BIT || `CS_DIR_BIT == `CS_RSV6_BIT) begin : g_bad_overlap
        $error("Status fields overlap");
    end

    if (`CS_UNF_BIT == `CS_RSV6_BIT || `CS_OVF_BIT == `CS_RSV6_BIT) begin : g_bad_reserved
        $error("Flag placed on the reserved bit");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    channel_status_pkg::state_s s_r;
    channel_status_pkg::state_s s_nxt;

    logic                        req;
    logic                        take;
    logic                        mapped;
    logic [`CS_CH_IDX_W-1:0]     ch_idx;
    logic                        wr_commit;
    logic [`CS_MAX_CHANNELS-1:0] populated;
    logic [`CS_MAX_CHANNELS-1:0] full;
    logic [`CS_MAX_CHANNELS-1:0] hit;
    logic [`CS_MAX_CHANNELS-1:0] rd_hit;
    logic [`CS_MAX_CHANNELS-1:0] wr_hit;
    logic [`CS_MAX_CHANNELS-1:0] unf_event;
    logic [`CS_MAX_CHANNELS-1:0] ovf_event;
    logic [`CS_MAX_CHANNELS-1:0] unf_clear;
    logic [`CS_MAX_CHANNELS-1:0] ovf_clear;
    logic [`CS_MAX_CHANNELS-1:0] unf_arm;
    logic [`CS_MAX_CHANNELS-1:0] ovf_arm;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Address to channel index; offsets step one word per channel
    function automatic logic [`CS_CH_IDX_W-1:0] chan_of(input logic [`CS_ADR_W-1:0] adr);
        logic [`CS_ADR_W-1:0] rel;
        rel = adr - `CS_STATUS_BASE;
        return rel[`CS_CH_IDX_W+1:2];
    endfunction

    // Only aligned words inside the populated channels answer with data
    function automatic logic is_mapped(input logic [`CS_ADR_W-1:0] adr);
        logic [`CS_ADR_W-1:0] rel;
        rel = adr - `CS_STATUS_BASE;
        return (adr >= `CS_STATUS_BASE)
            && (rel[1:0] == 2'h0)
            && (rel < `CS_ADR_W'(NUM_CHANNELS * `CS_STATUS_STRIDE));
    endfunction

    // Status byte as software sees it
    function automatic logic [7:0] status_byte(
        input channel_status_pkg::status_flags_s f,
        input logic [`CS_CH_IDX_W-1:0]           ch
    );
        logic [7:0] b;
        b = 8'h00;
        b[`CS_RSV6_BIT] = 1'b1;
        if (FULL_MASK[ch]) begin
            b[`CS_DIR_BIT] = f.count_direction_flag[ch];
            b[`CS_UNF_BIT] = f.underflow_flag[ch];
        end else begin
            b[`CS_DIR_BIT] = 1'b1;
            b[`CS_UNF_BIT] = 1'b0;
        end
        b[`CS_OVF_BIT] = f.overflow_flag[ch];
        return b;
    endfunction

    // Whole bus word for a read; unmapped words and upper bytes read zero
    function automatic logic [31:0] read_word(
        input channel_status_pkg::status_flags_s f,
        input logic [`CS_CH_IDX_W-1:0]           ch,
        input logic                              hit_any
    );
        logic [31:0] w;
        w = 32'h00000000;
        if (hit_any) begin
            w[7:0] = status_byte(f, ch);
        end
        return w;
    endfunction

    // Channels present in this build; the rest stay at reset values
    function automatic logic [`CS_MAX_CHANNELS-1:0] populated_mask();
        logic [`CS_MAX_CHANNELS-1:0] m;
        m = '0;
        for (int i = 0; i < `CS_MAX_CHANNELS; i++) begin
            if (i < NUM_CHANNELS) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // One-hot select of the addressed channel
    function automatic logic [`CS_MAX_CHANNELS-1:0] channel_decode(input logic [`CS_CH_IDX_W-1:0] ch);
        logic [`CS_MAX_CHANNELS-1:0] d;
        d = '0;
        for (int i = 0; i < `CS_MAX_CHANNELS; i++) begin
            if (ch == `CS_CH_IDX_W'(i)) begin
                d[i] = 1'b1;
            end
        end
        return d;
    endfunction

    // Sticky flag: the event wins over a clear in the same cycle
    function automatic logic [`CS_MAX_CHANNELS-1:0] sticky_next(
        input logic [`CS_MAX_CHANNELS-1:0] evt,
        input logic [`CS_MAX_CHANNELS-1:0] flag,
        input logic [`CS_MAX_CHANNELS-1:0] clear
    );
        return evt | (flag & ~clear);
    endfunction

    // Arming: a read of a one arms, a committed write to the same channel disarms
    function automatic logic [`CS_MAX_CHANNELS-1:0] arm_next(
        input logic [`CS_MAX_CHANNELS-1:0] armed,
        input logic [`CS_MAX_CHANNELS-1:0] arm,
        input logic [`CS_MAX_CHANNELS-1:0] disarm
    );
        return (armed | arm) & ~disarm;
    endfunction

    // Zero written to one bit, spread over all channels
    function automatic logic [`CS_MAX_CHANNELS-1:0] zero_written(
        input logic [31:0] dat,
        input int          bitpos
    );
        return {`CS_MAX_CHANNELS{~dat[bitpos]}};
    endfunction

    // Reset image of the whole state; direction reads as counting up
    function automatic channel_status_pkg::state_s reset_state();
        channel_status_pkg::state_s r;
        r                            = '0;
        r.flags.count_direction_flag = {`CS_MAX_CHANNELS{`CS_DIR_RESET}};
        r.flags.underflow_flag       = '0;
        r.flags.overflow_flag        = '0;
        r.unf_armed                  = '0;
        r.ovf_armed                  = '0;
        r.ack                        = 1'b0;
        r.rdata                      = 32'h00000000;
        return r;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_nxt     = s_r;
        s_nxt.ack = 1'b0;

        // ----------------------------------------
        // Bus decode
        // ----------------------------------------
        req       = wb_cyc_i & wb_stb_i;
        take      = req & ~s_r.ack;
        ch_idx    = chan_of(wb_adr_i);
        mapped    = is_mapped(wb_adr_i);
        populated = populated_mask();
        full      = FULL_MASK & populated;
        hit       = '0;
        if (mapped) begin
            hit = channel_decode(ch_idx) & populated;
        end
        rd_hit = '0;
        if (take && !wb_we_i) begin
            rd_hit = hit;
        end
        // Writes land on the edge where the master sees ack, not before
        wr_commit = req & wb_we_i & s_r.ack & wb_sel_i[0];
        wr_hit    = '0;
        if (wr_commit) begin
            wr_hit = hit;
        end

        // ----------------------------------------
        // Bus answer
        // ----------------------------------------
        // One cycle after the request; ack drops the cycle after
        if (take) begin
            s_nxt.ack   = 1'b1;
            s_nxt.rdata = read_word(s_r.flags, ch_idx, !wb_we_i && mapped);
        end

        // ----------------------------------------
        // Wrap events and software clears
        // ----------------------------------------
        unf_event = full & counter_events.phase_mode & counter_events.underflow;
        ovf_event = populated & counter_events.overflow;
        // Reading a one arms the later clearing write
        unf_arm   = rd_hit & s_r.flags.underflow_flag;
        ovf_arm   = rd_hit & s_r.flags.overflow_flag;
        // Writing one, or zero without the read, leaves the flag
        unf_clear = wr_hit & s_r.unf_armed & zero_written(wb_dat_i, `CS_UNF_BIT);
        ovf_clear = wr_hit & s_r.ovf_armed & zero_written(wb_dat_i, `CS_OVF_BIT);

        // ----------------------------------------
        // Flag and arming update
        // ----------------------------------------
        // Set wins over the clear so a coincident wrap is not lost
        s_nxt.flags.underflow_flag = sticky_next(unf_event, s_r.flags.underflow_flag, unf_clear);
        s_nxt.flags.overflow_flag  = sticky_next(ovf_event, s_r.flags.overflow_flag, ovf_clear);
        // Any write to the channel with the status byte selected consumes its arming, so a stale read cannot clear
        s_nxt.unf_armed = arm_next(s_r.unf_armed, unf_arm, wr_hit);
        s_nxt.ovf_armed = arm_next(s_r.ovf_armed, ovf_arm, wr_hit);

        for (int i = 0; i < `CS_MAX_CHANNELS; i++) begin
            if (!populated[i]) begin
                // Absent channels hold their reset values
                s_nxt.flags.count_direction_flag[i] = `CS_DIR_RESET;
                s_nxt.flags.underflow_flag[i]       = 1'b0;
                s_nxt.flags.overflow_flag[i]        = 1'b0;
                s_nxt.unf_armed[i]                  = 1'b0;
                s_nxt.ovf_armed[i]                  = 1'b0;
            end else if (!full[i]) begin
                // No direction or underflow hardware on these channels
                s_nxt.flags.count_direction_flag[i] = `CS_DIR_RESET;
                s_nxt.flags.underflow_flag[i]       = 1'b0;
                s_nxt.unf_armed[i]                  = 1'b0;
            end else begin
                s_nxt.flags.count_direction_flag[i] = counter_events.count_up[i];
            end
        end
    end

    // ----------------------------------------
    // Register
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            s_r <= reset_state();
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // Outputs, all straight from flip-flops
    // ----------------------------------------
    assign wb_ack_o     = s_r.ack;
    assign wb_dat_o     = s_r.rdata;
    assign status_flags = s_r.flags;

endmodule

// >>> include/channel_status_params.svh
// Offsets, field positions, reset values and counts of the channel status block.
// Assumes byte addresses on a 32-bit classic Wishbone bus, one word per register.
`ifndef CHANNEL_STATUS_PARAMS_SVH
`define CHANNEL_STATUS_PARAMS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define CS_MAX_CHANNELS     6
`define CS_CH_IDX_W         3
`define CS_STATUS_BASE      8'h00
`define CS_STATUS_STRIDE    8'h04
`define CS_ADR_W            8

// ----------------------------------------
// Fields of channel_status
// ----------------------------------------
`define CS_DIR_BIT          7
`define CS_RSV6_BIT         6
`define CS_UNF_BIT          5
`define CS_OVF_BIT          4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CS_DIR_RESET        1'b1
`define CS_FULL_MASK_RESET  6'h36

`endif

// >>> include/channel_status_pkg.sv
// Types shared by the channel status block and its surroundings.
// Assumes channel_status_params.svh is compiled in the same unit.
`include "channel_status_params.svh"

package channel_status_pkg;

    // ----------------------------------------
    // Per-channel events from the counter datapath
    // ----------------------------------------
    typedef struct packed {
        logic [`CS_MAX_CHANNELS-1:0] overflow;
        logic [`CS_MAX_CHANNELS-1:0] underflow;
        logic [`CS_MAX_CHANNELS-1:0] count_up;
        logic [`CS_MAX_CHANNELS-1:0] phase_mode;
    } counter_events_s;

    // ----------------------------------------
    // Flags presented to the rest of the timer
    // ----------------------------------------
    typedef struct packed {
        logic [`CS_MAX_CHANNELS-1:0] count_direction_flag;
        logic [`CS_MAX_CHANNELS-1:0] underflow_flag;
        logic [`CS_MAX_CHANNELS-1:0] overflow_flag;
    } status_flags_s;

    // ----------------------------------------
    // Whole state of the block
    // ----------------------------------------
    typedef struct packed {
        status_flags_s                flags;
        logic [`CS_MAX_CHANNELS-1:0] unf_armed;
        logic [`CS_MAX_CHANNELS-1:0] ovf_armed;
        logic                         ack;
        logic [31:0]                  rdata;
    } state_s;

endpackage

// >>> verification/timer_channel_status_flags_props.sv
// Assertions on the status flag block's bus and flag ports.
// Assumes the package compiles first; bound to the block below.
`timescale 1ns/100ps
module timer_channel_status_flags_props #(
    parameter int         NUM_CHANNELS = 6,
    parameter logic [5:0] FULL_MASK    = 6'h36
) (
    input wire logic                                clock,
    input wire logic                                resetn,
    input wire logic                                wb_cyc_i,
    input wire logic                                wb_stb_i,
    input wire logic                                wb_we_i,
    input wire logic [7:0]                          wb_adr_i,
    input wire logic [3:0]                          wb_sel_i,
    input wire logic [31:0]                         wb_dat_i,
    input wire logic [31:0]                         wb_dat_o,
    input wire logic                                wb_ack_o,
    input wire channel_status_pkg::counter_events_s counter_events,
    input wire channel_status_pkg::status_flags_s   status_flags
);
    // --------------------
    // Properties
    // --------------------
    wire [5:0] ov = status_flags.overflow_flag;
    wire [5:0] un = status_flags.underflow_flag;
    wire       rd = wb_ack_o && !wb_we_i;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
    property p_ack; s_take |=> s_ack; endproperty
    a_ack: assert property (p_ack) else $error("bad ack");
    property p_dir; $past(resetn) |-> status_flags.count_direction_flag[1] == $past(counter_events.count_up[1]);
    endproperty
    a_dir: assert property (p_dir) else $error("bad direction");
    property p_rsv; rd && wb_adr_i < 8'h18 && wb_adr_i[1:0] == 2'h0 |-> wb_dat_o[6]; endproperty
    a_rsv: assert property (p_rsv) else $error("bit 6 low");
    property p_ch0; rd && (wb_adr_i == 8'h00 || wb_adr_i == 8'h0c) |-> wb_dat_o[7:5] == 3'h6; endproperty
    a_ch0: assert property (p_ch0) else $error("reduced channel bits");
    property p_ovf; counter_events.overflow[3] |=> ov[3]; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not set");
    property p_unf; counter_events.underflow[1] && counter_events.phase_mode[1] |=> un[1]; endproperty
    a_unf: assert property (p_unf) else $error("underflow not set");
    // Falls only at a zero write; arming is left to the bench
    property p_cov; $past(resetn) && $fell(ov[3]) |-> $past(wb_ack_o && wb_we_i && !wb_dat_i[4]); endproperty
    a_cov: assert property (p_cov) else $error("overflow lost");
    property p_cun; $past(resetn) && $fell(un[1]) |-> $past(wb_ack_o && wb_we_i && !wb_dat_i[5]); endproperty
    a_cun: assert property (p_cun) else $error("underflow lost");
endmodule
bind timer_channel_status_flags timer_channel_status_flags_props #(
    .NUM_CHANNELS(NUM_CHANNELS), .FULL_MASK(FULL_MASK)
) props (
    .clock(clock), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .counter_events(counter_events), .status_flags(status_flags)
);

// >>> verification/tb.sv
// Testbench: Wishbone reads and writes of the channel status bytes.
// Assumes the package, design and checker compile before it.
`timescale 1ns/100ps
module tb;
    localparam logic [5:0] FM = 6'h36;
    logic                                clock = 1'b0;
    logic                                resetn = 1'b0;
    logic                                cyc = 1'b0;
    logic                                stb = 1'b0;
    logic                                we = 1'b0;
    logic [7:0]                          adr = 8'h00;
    logic [3:0]                          sel = 4'hf;
    logic [31:0]                         dat = 32'h0;
    logic [31:0]                         dat_o;
    logic                                ack;
    channel_status_pkg::counter_events_s ev = '0;
    channel_status_pkg::status_flags_s   flags;
    int                                  failures = 0;
    int                                  compares = 0;
    always #50 clock = ~clock;
    timer_channel_status_flags #(.NUM_CHANNELS(6), .FULL_MASK(FM)) timer_channel_status_flags_inst (
        .clock(clock), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .counter_events(ev), .status_flags(flags)
    );
    // --------------------
    // Tasks
    // --------------------
    task automatic close_out();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clock); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check("channel_status", q, e);
    endtask
    task automatic pulse(input logic [5:0] o, input logic [5:0] u);
        @(posedge clock);
        ev.overflow <= o;
        ev.underflow <= u;
        @(posedge clock);
        ev.overflow <= 6'h00;
        ev.underflow <= 6'h00;
    endtask
    function automatic logic [31:0] ex(int c, logic [2:0] f);
        return {24'h0, f[2] | ~FM[c], 1'b1, f[1] & FM[c], f[0], 4'h0};
    endfunction
    // --------------------
    // Tests
    // --------------------
    initial begin
        repeat (2000) @(posedge clock);
        failures++;
        close_out();
    end
    initial begin
        logic [31:0] q;
        ev.count_up <= 6'h3f;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        for (int c = 0; c < 6; c++) rd(8'(4 * c), ex(c, 3'h4));
        ev.count_up <= 6'h00;
        for (int c = 0; c < 6; c++) rd(8'(4 * c), ex(c, 3'h0));
        check("count_direction_flag", 32'(flags.count_direction_flag), 32'h09);
        ev.count_up <= 6'h3f;
        ev.phase_mode <= 6'h3f;
        pulse(6'h3f, 6'h3f);
        @(posedge clock);
        check("overflow_flag", 32'(flags.overflow_flag), 32'h3f);
        check("underflow_flag", 32'(flags.underflow_flag), 32'h36);
        // Unarmed zero write must not clear
        bus(1'b1, 8'h04, 32'h0, q);
        for (int c = 0; c < 6; c++) rd(8'(4 * c), ex(c, 3'h7));
        bus(1'b1, 8'h04, 32'h30, q);
        rd(8'h04, ex(1, 3'h7));
        // Held through the write so wrap and clear coincide
        ev.overflow <= 6'h04;
        bus(1'b1, 8'h08, 32'h0, q);
        ev.overflow <= 6'h00;
        rd(8'h08, ex(2, 3'h5));
        bus(1'b1, 8'h04, 32'h0, q);
        rd(8'h04, ex(1, 3'h4));
        bus(1'b1, 8'h0c, 32'h0, q);
        rd(8'h0c, ex(3, 3'h4));
        // Zero write with the status byte deselected is ignored
        sel <= 4'he;
        bus(1'b1, 8'h10, 32'h0, q);
        sel <= 4'hf;
        rd(8'h10, ex(4, 3'h7));
        ev.phase_mode <= 6'h00;
        pulse(6'h00, 6'h3f);
        rd(8'h04, ex(1, 3'h4));
        rd(8'h40, 32'h0);
        close_out();
    end
endmodule
